/* common/safc_defines.vh */
// Constants for the serial frame and sequencing logic of the SAR converter.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SAFC_DEFINES_VH
`define SAFC_DEFINES_VH

// ============================================================
// Register map (byte addresses, one aligned word each)
`define SAFC_OFS_CTRL 8'h00
`define SAFC_OFS_STATUS 8'h04
`define SAFC_OFS_CONFIG 8'h08
`define SAFC_OFS_RESULT 8'h0c
`define SAFC_OFS_COUNT 8'h10
`define SAFC_CTRL_EN_BIT 0
`define SAFC_CTRL_RESET 1'b1
`define SAFC_RESULT_NEW_BIT 16
`define SAFC_RESP_OKAY 2'b00
`define SAFC_RESP_SLVERR 2'b10

// ============================================================
// Frame layout
`define SAFC_BYTE_CLOCKS 8
`define SAFC_FRAME_CLOCKS 24
`define SAFC_RES_BITS 16
`define SAFC_MUX_SET_COUNT 4'd5
`define SAFC_MODE_SET_COUNT 4'd6
`define SAFC_HOLD_COUNT 4'd8
`define SAFC_LAST_DECISION 5'd15
`define SAFC_CB_CH_HI 3
`define SAFC_CB_CH_LO 1
`define SAFC_CB_SGL 2
`define SAFC_CB_PD_HI 1
`define SAFC_CB_PD_LO 0
`define SAFC_PD_AUTO 2'b00
`define SAFC_PD_RSVD 2'b01
`define SAFC_PD_INT 2'b10
`define SAFC_PD_EXT 2'b11
`define SAFC_SAR_MSB 16'h8000

// ============================================================
// Timing
`define SAFC_CLK_PERIOD_NS 8
`define SAFC_INT_STEP_NS 400
// One internal decision step of 400 ns at 8 ns per clock, sized for the 16-bit count.
`define SAFC_INT_STEP_CYCLES 16'd50

`endif

/* rtl/safc_sync2.v */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; the clock enable freezes it too.
module safc_sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // safc_sync2

/* rtl/safc_frame_ctrl.v */
// Serial frame control of a 16-bit, 4-channel SAR converter with AXI4-Lite status.
// Assumes pins come from another domain, comparator_hi and the bus from aclk.
// Behaviour
// - Exchanges come in groups of eight clocks.
// - One conversion fits in 24 shift clocks.
// - Set multiplexer early, then start acquiring (code does both on the fifth clock; the mode bit reaches the mux on the sixth).
// - Three clocks later switch to hold, convert.
// - Sixteen shift clocks perform the conversion.
// - Choose single-ended or differential input pairing.
// - Result is sixteen bits, 65536 codes.
// - Ignore input bits until high start bit.
// - Control byte: start, channel, spare, mode, power.
// - Busy one clock, then 16 result bits.
// - Power bits choose clock and power-down mode.
`include "safc_defines.vh"

module safc_frame_ctrl #(
  parameter ADDR_W = 8,
  parameter [15:0] INT_STEP_CYCLES = `SAFC_INT_STEP_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire shift_clock,
  input wire serial_din,
  input wire select_n,
  input wire shutdown_n,
  output reg serial_dout,
  output reg serial_dout_oe,
  output reg busy,
  output reg busy_oe,
  output reg [4:0] mux_pos_sel,
  output reg [4:0] mux_neg_sel,
  output reg sample_hold,
  output reg powered_up,
  output reg [15:0] dac_code,
  input wire comparator_hi
);

  // ============================================================
  // States and helpers
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CTRL = 3'd1;
  localparam [2:0] ST_BUSY = 3'd2;
  localparam [2:0] ST_CONV = 3'd3;
  localparam [2:0] ST_INT = 3'd4;
  localparam [2:0] ST_OUT = 3'd5;

  // One successive-approximation step: drop the trial bit if the sample is lower, try the next.
  function [15:0] sar_step;
    input [15:0] code;
    input [15:0] trial;
    input cmp;
    reg [15:0] c;
    begin
      c = cmp ? code : (code & ~trial);
      sar_step = c | (trial >> 1);
    end
  endfunction

  // Multiplexer decode, one-hot over {COM, CH3, CH2, CH1, CH0}, returns {positive, negative}.
  function [9:0] mux_decode;
    input [2:0] chan;
    input sgl;
    begin
      case ({sgl, chan})
        4'b1001: mux_decode = {5'b00001, 5'b10000};
        4'b1101: mux_decode = {5'b00010, 5'b10000};
        4'b1010: mux_decode = {5'b00100, 5'b10000};
        4'b1110: mux_decode = {5'b01000, 5'b10000};
        4'b0001: mux_decode = {5'b00001, 5'b00010};
        4'b0101: mux_decode = {5'b00010, 5'b00001};
        4'b0010: mux_decode = {5'b00100, 5'b01000};
        4'b0110: mux_decode = {5'b01000, 5'b00100};
        default: mux_decode = 10'h000;
      endcase
    end
  endfunction

  // ============================================================
  // Pin synchronisation
  wire [3:0] pins_s;
  safc_sync2 #(
    .WIDTH(4),
    .RST_VAL(4'b1100)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in({shutdown_n, select_n, serial_din, shift_clock}),
    .sync_out(pins_s)
  );
  wire sclk_s = pins_s[0];
  wire din_s = pins_s[1];
  wire sel_n_s = pins_s[2];
  wire shutdown_n_n_s = pins_s[3];

  reg enable_r;
  reg [2:0] state_r;
  reg sclk_d_r;
  reg [7:0] ctrl_sr_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] ctrl_byte_r;
  reg [2:0] chan_r;
  reg sgl_r;
  reg [1:0] pd_r;
  reg clk_int_r;
  reg [15:0] trial_r;
  reg [4:0] dec_cnt_r;
  reg [15:0] tick_r;
  reg [15:0] result_r;
  reg [15:0] shift_r;
  reg [15:0] conv_count_r;
  reg done_p_r;
  reg result_new_r;

  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire active = ~sel_n_s & enable_r & shutdown_n_n_s;
  wire [7:0] sr_shift = {ctrl_sr_r[6:0], din_s};
  wire [3:0] cnt_inc = bit_cnt_r + 4'd1;
  wire [1:0] pd_new = sr_shift[`SAFC_CB_PD_HI:`SAFC_CB_PD_LO];
  // clock mode kept unless power bits name one
  wire clk_int_new = (pd_new == `SAFC_PD_INT) ? 1'b1 : (pd_new == `SAFC_PD_EXT) ? 1'b0 : clk_int_r;
  wire [15:0] sar_nxt = sar_step(dac_code, trial_r, comparator_hi);

  // ============================================================
  // Frame sequencing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      sclk_d_r <= 1'b0;
      ctrl_sr_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      ctrl_byte_r <= 8'h00;
      chan_r <= 3'h0;
      sgl_r <= 1'b0;
      pd_r <= `SAFC_PD_AUTO;
      clk_int_r <= 1'b0;
      trial_r <= 16'h0000;
      dec_cnt_r <= 5'h00;
      tick_r <= 16'h0000;
      result_r <= 16'h0000;
      shift_r <= 16'h0000;
      conv_count_r <= 16'h0000;
      done_p_r <= 1'b0;
      serial_dout <= 1'b0;
      serial_dout_oe <= 1'b0;
      busy <= 1'b0;
      busy_oe <= 1'b0;
      mux_pos_sel <= 5'h00;
      mux_neg_sel <= 5'h00;
      sample_hold <= 1'b1;
      powered_up <= 1'b0;
      dac_code <= 16'h0000;
    end
    else if (ce)
    begin
      done_p_r <= 1'b0;
      sclk_d_r <= sclk_s;
      serial_dout_oe <= ~sel_n_s & enable_r;
      busy_oe <= ~sel_n_s & enable_r;
      // power state follows mode and shutdown
      powered_up <= shutdown_n_n_s & ((state_r != ST_IDLE) | (pd_r != `SAFC_PD_AUTO));
      if (!active)
      begin
        state_r <= ST_IDLE;
        busy <= 1'b0;
        serial_dout <= 1'b0;
        sample_hold <= 1'b1;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            if (fall)
              serial_dout <= 1'b0;
            if (rise && din_s)
            begin
              ctrl_sr_r <= 8'h01;
              bit_cnt_r <= 4'd1;
              state_r <= ST_CTRL;
            end
          end
          ST_CTRL:
          begin
            if (fall)
              serial_dout <= 1'b0;
            if (rise)
            begin
              ctrl_sr_r <= sr_shift;
              bit_cnt_r <= cnt_inc;
              if (cnt_inc == `SAFC_MUX_SET_COUNT)
              begin
                chan_r <= sr_shift[`SAFC_CB_CH_HI:`SAFC_CB_CH_LO];
                {mux_pos_sel, mux_neg_sel} <= mux_decode(sr_shift[`SAFC_CB_CH_HI:`SAFC_CB_CH_LO], sgl_r);
                sample_hold <= 1'b0;
              end
              if (cnt_inc == `SAFC_MODE_SET_COUNT)
              begin
                sgl_r <= sr_shift[0];
                {mux_pos_sel, mux_neg_sel} <= mux_decode(chan_r, sr_shift[0]);
              end
              if (cnt_inc == `SAFC_HOLD_COUNT)
              begin
                ctrl_byte_r <= sr_shift;
                pd_r <= pd_new;
                clk_int_r <= clk_int_new;
                sample_hold <= 1'b1;
                dac_code <= `SAFC_SAR_MSB;
                trial_r <= `SAFC_SAR_MSB;
                dec_cnt_r <= 5'h00;
                tick_r <= 16'h0000;
                if (clk_int_new)
                begin
                  busy <= 1'b1;
                  state_r <= ST_INT;
                end
                else
                  state_r <= ST_BUSY;
              end
            end
          end
          ST_BUSY:
          begin
            if (fall)
            begin
              busy <= 1'b1;
              state_r <= ST_CONV;
            end
          end
          ST_CONV:
          begin
            if (fall)
            begin
              busy <= 1'b0;
              serial_dout <= comparator_hi;
              dac_code <= sar_nxt;
              trial_r <= trial_r >> 1;
              dec_cnt_r <= dec_cnt_r + 5'd1;
              if (dec_cnt_r == `SAFC_LAST_DECISION)
              begin
                result_r <= sar_nxt;
                done_p_r <= 1'b1;
                conv_count_r <= conv_count_r + 16'd1;
                state_r <= ST_IDLE;
              end
            end
          end
          ST_INT:
          begin
            if (fall)
              serial_dout <= 1'b0;
            if (tick_r == INT_STEP_CYCLES - 16'd1)
            begin
              tick_r <= 16'h0000;
              dac_code <= sar_nxt;
              trial_r <= trial_r >> 1;
              dec_cnt_r <= dec_cnt_r + 5'd1;
              if (dec_cnt_r == `SAFC_LAST_DECISION)
              begin
                result_r <= sar_nxt;
                shift_r <= sar_nxt;
                done_p_r <= 1'b1;
                conv_count_r <= conv_count_r + 16'd1;
                busy <= 1'b0;
                dec_cnt_r <= 5'h00;
                state_r <= ST_OUT;
              end
            end
            else
              tick_r <= tick_r + 16'd1;
          end
          ST_OUT:
          begin
            if (fall)
            begin
              serial_dout <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'b0};
              dec_cnt_r <= dec_cnt_r + 5'd1;
              if (dec_cnt_r == `SAFC_LAST_DECISION)
                state_r <= ST_IDLE;
            end
          end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // AXI4-Lite slave
  reg aw_hold_r;
  reg w_hold_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire rd_result = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `SAFC_OFS_RESULT);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAFC_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      enable_r <= `SAFC_CTRL_RESET;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SAFC_RESP_OKAY;
        if (aw_addr_r == `SAFC_OFS_CTRL)
        begin
          if (w_strb_r[0])
            enable_r <= w_data_r[`SAFC_CTRL_EN_BIT];
        end
        else if ((aw_addr_r != `SAFC_OFS_STATUS) && (aw_addr_r != `SAFC_OFS_CONFIG) &&
                 (aw_addr_r != `SAFC_OFS_RESULT) && (aw_addr_r != `SAFC_OFS_COUNT))
          s_axi_bresp <= `SAFC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SAFC_RESP_OKAY;
      result_new_r <= 1'b0;
    end
    else if (ce)
    begin
      // A finished conversion in the same cycle as the read keeps the flag set.
      if (done_p_r)
        result_new_r <= 1'b1;
      else if (rd_result)
        result_new_r <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SAFC_RESP_OKAY;
        case (s_axi_araddr)
          `SAFC_OFS_CTRL: s_axi_rdata <= {31'h0, enable_r};
          `SAFC_OFS_STATUS: s_axi_rdata <= {25'h0, powered_up, clk_int_r, sample_hold, busy, state_r};
          `SAFC_OFS_CONFIG: s_axi_rdata <= {16'h0, pd_r, sgl_r, chan_r, 2'b00, ctrl_byte_r};
          `SAFC_OFS_RESULT: s_axi_rdata <= {15'h0, result_new_r, result_r};
          `SAFC_OFS_COUNT: s_axi_rdata <= {16'h0, conv_count_r};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SAFC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // safc_frame_ctrl

/* sim/safc_frame_ctrl_props.sv */
// Concurrent checks on bus handshakes and the conversion frame.
// Assumes binding into the frame control top; ce drops only while the bus is quiet.
module safc_frame_ctrl_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire select_n,
  input wire shutdown_n,
  input wire serial_dout_oe,
  input wire busy_oe,
  input wire busy,
  input wire sample_hold,
  input wire powered_up
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence acq_open; $fell(sample_hold); endsequence
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_answer_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  oe_pair_a: assert property (serial_dout_oe == busy_oe)
    else $error("enables differ");
  busy_len_a: assert property ($rose(busy) |-> busy [*7])
    else $error("busy too short");
  deselect_idle_a: assert property (select_n [*6] |-> !serial_dout_oe && !busy && sample_hold)
    else $error("deselect not idle");
  acquire_quiet_a: assert property (!sample_hold |-> !busy)
    else $error("busy while acquiring");
  shutdown_off_a: assert property (!shutdown_n [*5] |-> !powered_up)
    else $error("powered in shutdown");
  acquire_len_a: assert property (acq_open |-> !sample_hold [*8] ##[10:20] sample_hold)
    else $error("acquisition length");
endmodule // safc_frame_ctrl_props

bind safc_frame_ctrl safc_frame_ctrl_props u_props (.*);

/* sim/safc_host_model.sv */
// Host serial port: shifts a frame out, samples replies before each fall.
// Assumes a 64 ns shift clock that stands low outside frames.
module safc_host_model (
  output logic shift_clock,
  output logic serial_din,
  output logic select_n,
  input wire logic serial_dout,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Frame driver
  initial
  begin
    shift_clock = 1'b0;
    serial_din = 1'b0;
    select_n = 1'b1;
  end
  // bytes MSB first, frames of whole clocks.
  task automatic run(input logic [63:0] b, input int n, input bit keep, output logic [63:0] dv,
                     output logic [63:0] bv);
    dv = '0;
    bv = '0;
    select_n = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      serial_din = b[63-k];
      #32 shift_clock = 1'b1;
      #31 dv = {dv[62:0], serial_dout};
      bv = {bv[62:0], busy};
      #1 shift_clock = 1'b0;
    end
    serial_din = ~serial_din;
    #32 select_n = !keep;
  endtask
endmodule // safc_host_model

/* sim/safc_frame_ctrl_tb_top.sv */
// Self-checking bench of the converter frame control.
// Assumes the host model drives the pins and a comparator follows dac_code.
module safc_frame_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] cb; logic [15:0] val; logic [4:0] pos; logic [4:0] neg;} safc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, shutdown_n = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_dout, serial_dout_oe;
  logic busy, busy_oe, sample_hold, powered_up, shift_clock, serial_din, select_n;
  logic [4:0] mux_pos_sel, mux_neg_sel;
  logic [15:0] dac_code, ana = 16'h0;
  logic [63:0] dv, bv;
  wire comparator_hi = ana >= dac_code;
  int fails = 0, samples_checked = 0;
  safc_row_t rows [8] = '{'{8'h97, 16'h1234, 5'h01, 5'h10}, '{8'hd7, 16'hffff, 5'h02, 5'h10},
    '{8'ha7, 16'h0000, 5'h04, 5'h10}, '{8'he7, 16'h8001, 5'h08, 5'h10}, '{8'h93, 16'h7ffe, 5'h01, 5'h02},
    '{8'hd3, 16'h5a5a, 5'h02, 5'h01}, '{8'ha3, 16'h00ff, 5'h04, 5'h08}, '{8'he3, 16'ha5a5, 5'h08, 5'h04}};
  logic [7:0] modes [2] = '{8'h96, 8'h94};
  safc_frame_ctrl #(.INT_STEP_CYCLES(16'h0002)) dut (.*);
  safc_host_model hm (.*);
  // ============================================================
  // Helpers
  initial forever #4 aclk = ~aclk;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw = 1, w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge aclk);
    fails++;
    wrap_up();
  end
  // ============================================================
  // Tests
  initial
  begin
    repeat (8) @(posedge aclk);
    chk({s_axi_awready, s_axi_bvalid, sample_hold, powered_up, serial_dout_oe}, 64'h14);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(8'h00, rd, rs);
    chk({rs, rd}, 64'h1);
    axi_rd(8'h14, rd, rs);
    chk({rs, rd}, 64'h2_0000_0000);
    axi_wr(8'h14, 32'h0, 4'hf, rs);
    chk(rs, 64'h2);
    axi_wr(8'h00, 32'h0, 4'h0, rs);
    axi_rd(8'h00, rd, rs);
    chk(rd, 64'h1);
    $display("test registers done");
    foreach (rows[i])
    begin
      ana <= rows[i].val;
      hm.run({rows[i].cb, 56'h0}, 8, 1, dv, bv);
      repeat (10) @(posedge aclk);
      chk({mux_pos_sel, mux_neg_sel, sample_hold}, {rows[i].pos, rows[i].neg, 1'b1});
      hm.run('0, 24, 0, dv, bv);
      chk(dv, {rows[i].val, 7'h0});
      chk(bv, 64'h80_0000);
    end
    $display("test rows done");
    ana <= 16'h3c3c;
    hm.run({8'h97, 16'h0, 8'h97, 32'h0}, 56, 0, dv, bv);
    chk(dv, {16'h3c3c, 8'h0, 16'h3c3c, 7'h0});
    chk(bv, 64'h8000_0080_0000);
    chk((dv[46:31] + dv[22:7]) >> 1, 64'h3c3c);
    hm.run({3'b000, 8'h97, 53'h0}, 35, 0, dv, bv);
    chk(dv, {16'h3c3c, 7'h0});
    chk(bv, 64'h80_0000);
    axi_rd(8'h0c, rd, rs);
    chk(rd, 64'h1_3c3c);
    axi_rd(8'h0c, rd, rs);
    chk(rd, 64'h3c3c);
    axi_rd(8'h08, rd, rs);
    chk(rd[7:0], 64'h97);
    shutdown_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(powered_up, 64'h0);
    ce <= 1'b0;
    shutdown_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(powered_up, 64'h0);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(powered_up, 64'h1);
    $display("test overlap done");
    hm.run({8'h97, 56'h0}, 12, 1, dv, bv);
    hm.run('0, 0, 0, dv, bv);
    repeat (10) @(posedge aclk);
    chk({busy, serial_dout, serial_dout_oe, sample_hold}, 64'h1);
    axi_wr(8'h00, 32'h0, 4'h1, rs);
    hm.run({8'h97, 56'h0}, 32, 0, dv, bv);
    chk(bv, 64'h0);
    axi_wr(8'h00, 32'h1, 4'h1, rs);
    $display("test abort done");
    foreach (modes[j])
    begin
      hm.run({modes[j], 56'h0}, 8, 1, dv, bv);
      repeat (6) @(posedge aclk);
      chk(busy, 64'h1);
      repeat (40) @(posedge aclk);
      chk(busy, 64'h0);
      hm.run('0, 17, 0, dv, bv);
      chk(dv, 64'h3c3c);
      repeat (10) @(posedge aclk);
      chk(powered_up, modes[j][1]);
    end
    axi_rd(8'h10, rd, rs);
    chk(rd, 64'hd);
    $display("test internal done");
    wrap_up();
  end
endmodule // safc_frame_ctrl_tb_top
